//--- pmic_pkg.sv
// shared constants for the power sequencer and its processor-side controller
package pmic_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h5B;
  localparam logic [7:0] OFS_VOLTAGE = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h11;
  localparam logic [7:0] OFS_RESERVED = 8'h12;
  localparam logic [7:0] OFS_CTRL_STATUS = 8'h13;
  localparam int OUTPUT_VOLTAGE_SELECT_LSB = 0;
  localparam int OUTPUT_VOLTAGE_SELECT_W = 6;
  localparam int SPAN_BIT = 6;
  localparam int MODE_BIT = 0;
  localparam int ON_BIT = 0;
  localparam int OK_BIT = 1;
  localparam int WEXACT_BIT = 2;
  localparam logic [6:0] VOLTAGE_RST = 7'h00;
  localparam logic MODE_RST = 1'b0;
  localparam logic ON_RST = 1'b1;
  localparam logic WEXACT_RST = 1'b0;
  localparam int CLK_PERIOD_PS = 4000;
  localparam longint RESET_TIMEOUT_MS = 260;
  localparam longint RESET_TIMEOUT_CYC = RESET_TIMEOUT_MS * 1000000000 / CLK_PERIOD_PS;
  localparam int SCL_HALF_CYC = 16;
  // controller register map (APB byte addresses)
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_PINS = 8'h08;
endpackage

//--- pmic_link_if.sv
// link between the power sequencer and the system processor
`timescale 1ns/10ps
interface pmic_link_if;
  logic scl;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda;
  logic push_button_enable_n;
  logic power_hold;
  logic buck3_enable_in;
  logic reset_sink_oe;
  logic processor_reset_out_n;
  assign sda = ~((sda_dev_oe & ~sda_dev_out) | (sda_host_oe & ~sda_host_out));
  assign processor_reset_out_n = ~reset_sink_oe;
  modport device (
    input scl, sda, push_button_enable_n, power_hold, buck3_enable_in,
    output sda_dev_out, sda_dev_oe, reset_sink_oe
  );
  modport host (
    input sda, processor_reset_out_n,
    output scl, sda_host_out, sda_host_oe, power_hold, buck3_enable_in
  );
endinterface

//--- sync2.sv
// two-flop synchroniser for one level
`timescale 1ns/10ps
module sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic q_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule // sync2

//--- pmic_sequencer.sv
// device end: enable sequencing, reset timer, thermal cutoff, serial register slave
`timescale 1ns/10ps
module pmic_sequencer
  import pmic_pkg::*;
#(
  parameter longint RESET_CYC = RESET_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  pmic_link_if.device link,
  input wire logic temp_over_160,
  input wire logic temp_below_140,
  input wire logic buck1_output_ok,
  output logic buck_regulator_1,
  output logic buck_regulator_2,
  output logic buck_regulator_3,
  output logic linear_regulator_4,
  output logic [5:0] output_voltage_select,
  output logic output_span_select,
  output logic forced_pwm
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ADDR = 6'b000010,
    S_ACK = 6'b000100,
    S_WDATA = 6'b001000,
    S_RDATA = 6'b010000,
    S_RACK = 6'b100000
  } slave_e;

  logic scl_s, sda_s, btn_n_s, hold_s, on3_s;
  sync2 #(.RST_VAL(1'b1)) u_scl (.pclk(pclk), .presetn(presetn), .d(link.scl), .q(scl_s));
  sync2 #(.RST_VAL(1'b1)) u_sda (.pclk(pclk), .presetn(presetn), .d(link.sda), .q(sda_s));
  sync2 #(.RST_VAL(1'b1)) u_btn (.pclk(pclk), .presetn(presetn), .d(link.push_button_enable_n),
    .q(btn_n_s));
  // hold and buck3 pins idle low: a high reset value would enable regulators after reset
  sync2 #(.RST_VAL(1'b0)) u_hld (.pclk(pclk), .presetn(presetn), .d(link.power_hold),
    .q(hold_s));
  sync2 #(.RST_VAL(1'b0)) u_on3 (.pclk(pclk), .presetn(presetn), .d(link.buck3_enable_in),
    .q(on3_s));

  // power control
  logic btn_prev_ff, thermal_ff, rst_sink_ff;
  logic [39:0] rst_cnt_ff;
  logic enabled;
  assign enabled = (~btn_n_s | hold_s) & ~thermal_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) thermal_ff <= 1'b0;
    else if (temp_over_160) thermal_ff <= 1'b1;
    else if (temp_below_140) thermal_ff <= 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) btn_prev_ff <= 1'b1;
    else btn_prev_ff <= btn_n_s;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sink_ff <= 1'b0;
      rst_cnt_ff <= '0;
    end else if (!enabled) begin
      rst_sink_ff <= 1'b0;
      rst_cnt_ff <= '0;
    end else if (btn_prev_ff && !btn_n_s && !rst_sink_ff) begin
      rst_sink_ff <= 1'b1;
      rst_cnt_ff <= 40'(RESET_CYC - 1);
    end else if (rst_sink_ff) begin
      if (rst_cnt_ff == '0) rst_sink_ff <= 1'b0;
      else rst_cnt_ff <= rst_cnt_ff - 40'd1;
    end
  end
  assign link.reset_sink_oe = rst_sink_ff;

  // register bits
  logic [5:0] output_voltage_select_ff;
  logic span_ff, mode_ff, on_ff, wexact_ff;
  logic [7:0] reg_ptr_ff, shift_ff, rd_byte;
  assign buck_regulator_1 = enabled & on_ff;
  assign buck_regulator_2 = enabled;
  assign linear_regulator_4 = enabled;
  assign buck_regulator_3 = enabled & (~btn_n_s | on3_s);
  assign output_voltage_select = output_voltage_select_ff;
  assign output_span_select = span_ff;
  assign forced_pwm = mode_ff;

  // serial slave
  slave_e st_ff;
  logic scl_prev_ff, sda_prev_ff, is_read_ff, have_ptr_ff, addr_hit_ff, sda_low_ff;
  logic [3:0] bit_ff;
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_prev_ff;
  assign scl_fall = ~scl_s & scl_prev_ff;
  assign start_c = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign stop_c = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
    end
  end
  always_comb begin
    rd_byte = 8'h00;
    case (reg_ptr_ff)
      OFS_VOLTAGE: rd_byte = {1'b0, span_ff, output_voltage_select_ff};
      OFS_MODE: rd_byte = {7'h00, mode_ff};
      OFS_CTRL_STATUS: rd_byte = {5'h00, wexact_ff, buck1_output_ok, on_ff};
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= S_IDLE;
      bit_ff <= '0;
      shift_ff <= '0;
      is_read_ff <= 1'b0;
      have_ptr_ff <= 1'b0;
      addr_hit_ff <= 1'b0;
      reg_ptr_ff <= '0;
      sda_low_ff <= 1'b0;
      output_voltage_select_ff <= VOLTAGE_RST[5:0];
      span_ff <= VOLTAGE_RST[SPAN_BIT];
      mode_ff <= MODE_RST;
      on_ff <= ON_RST;
      wexact_ff <= WEXACT_RST;
    end else if (start_c) begin
      st_ff <= S_ADDR;
      bit_ff <= '0;
      sda_low_ff <= 1'b0;
      have_ptr_ff <= 1'b0;
    end else if (stop_c) begin
      st_ff <= S_IDLE;
      sda_low_ff <= 1'b0;
    end else begin
      case (st_ff)
        S_IDLE: sda_low_ff <= 1'b0;
        S_ADDR, S_WDATA: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_s};
            bit_ff <= bit_ff + 4'd1;
          end else if (scl_fall && bit_ff == 4'd8) begin
            bit_ff <= '0;
            if (st_ff == S_ADDR) begin
              addr_hit_ff <= (shift_ff[7:1] == SLAVE_ADDR);
              is_read_ff <= shift_ff[0];
              sda_low_ff <= (shift_ff[7:1] == SLAVE_ADDR);
              st_ff <= (shift_ff[7:1] == SLAVE_ADDR) ? S_ACK : S_IDLE;
            end else begin
              sda_low_ff <= 1'b1;
              st_ff <= S_ACK;
              if (!have_ptr_ff) begin
                reg_ptr_ff <= shift_ff;
                have_ptr_ff <= 1'b1;
              end else begin
                case (reg_ptr_ff)
                  OFS_VOLTAGE: begin
                    output_voltage_select_ff <= shift_ff[OUTPUT_VOLTAGE_SELECT_LSB +: OUTPUT_VOLTAGE_SELECT_W];
                    span_ff <= shift_ff[SPAN_BIT];
                  end
                  OFS_MODE: mode_ff <= shift_ff[MODE_BIT];
                  OFS_CTRL_STATUS: begin
                    on_ff <= shift_ff[ON_BIT];
                    wexact_ff <= shift_ff[WEXACT_BIT];
                  end
                  default: ;
                endcase
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            bit_ff <= '0;
            if (is_read_ff) begin
              st_ff <= S_RDATA;
              shift_ff <= rd_byte;
              sda_low_ff <= ~rd_byte[7];
            end else begin
              st_ff <= S_WDATA;
              sda_low_ff <= 1'b0;
            end
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            bit_ff <= bit_ff + 4'd1;
            if (bit_ff == 4'd7) begin
              sda_low_ff <= 1'b0;
              st_ff <= S_RACK;
            end else begin
              sda_low_ff <= ~shift_ff[6];
              shift_ff <= {shift_ff[6:0], 1'b0};
            end
          end
        end
        S_RACK: begin
          if (scl_rise) st_ff <= S_IDLE;
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe = sda_low_ff & addr_hit_ff;
endmodule // pmic_sequencer

//--- pmic_host.sv
// processor end: APB-controlled serial master and power-hold driver
`timescale 1ns/10ps
module pmic_host
  import pmic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pmic_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic hold_ff, on3_ff, busy_ff, nack_ff, rd_ff, scl_ff, sda_low_ff;
  logic [7:0] rdat_ff;
  logic [6:0] step_ff;
  logic [4:0] div_ff;
  logic [26:0] frame_ff;
  logic [6:0] stop_step, ack_step;
  logic rst_s, sda_s;
  sync2 #(.RST_VAL(1'b1)) u_rst (.pclk(pclk), .presetn(presetn),
    .d(link.processor_reset_out_n), .q(rst_s));
  sync2 #(.RST_VAL(1'b1)) u_sda (.pclk(pclk), .presetn(presetn), .d(link.sda), .q(sda_s));
  // third byte's ack slot and the stop's low half period depend on the frame kind
  assign stop_step = rd_ff ? 7'h4c : 7'h36;
  assign ack_step = rd_ff ? 7'h39 : 7'h35;
  logic wr_acc;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      APB_STATUS: prdata = {21'h00_0000, rst_s, nack_ff, busy_ff, rdat_ff};
      APB_PINS: prdata = {30'h0000_0000, on3_ff, hold_ff};
      default: prdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 1'b0;
      on3_ff <= 1'b0;
    end else if (wr_acc && paddr == APB_PINS) begin
      hold_ff <= pwdata[0];
      on3_ff <= pwdata[1];
    end
  end
  assign link.power_hold = hold_ff;
  assign link.buck3_enable_in = on3_ff;
  // frame: start, 3 or 4 bytes with acks, stop; step counts scl half periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      nack_ff <= 1'b0;
      rd_ff <= 1'b0;
      rdat_ff <= '0;
      frame_ff <= '0;
      step_ff <= '0;
      div_ff <= '0;
      scl_ff <= 1'b1;
      sda_low_ff <= 1'b0;
    end else if (!busy_ff) begin
      if (wr_acc && paddr == APB_CMD) begin
        busy_ff <= 1'b1;
        nack_ff <= 1'b0;
        rd_ff <= pwdata[16];
        frame_ff <= {SLAVE_ADDR, 1'b0, 1'b1, pwdata[15:8], 1'b1, pwdata[7:0], 1'b1};
        step_ff <= '0;
        div_ff <= '0;
        sda_low_ff <= 1'b1;
      end
    end else if (div_ff != 5'(SCL_HALF_CYC - 1)) begin
      div_ff <= div_ff + 5'd1;
    end else begin
      div_ff <= '0;
      step_ff <= step_ff + 7'h01;
      if (step_ff == stop_step + 7'h02) begin
        // stop: data released one half period after the clock went high
        sda_low_ff <= 1'b0;
        busy_ff <= 1'b0;
        rd_ff <= 1'b0;
      end else if (step_ff == stop_step) begin
        scl_ff <= 1'b0;
        sda_low_ff <= 1'b1;
      end else if (rd_ff && step_ff == 7'h24) begin
        scl_ff <= 1'b0;
        sda_low_ff <= 1'b0;
      end else if (rd_ff && step_ff == 7'h26) begin
        // repeated start with the clock held high, then address with read bit
        sda_low_ff <= 1'b1;
        frame_ff <= {SLAVE_ADDR, 1'b1, 1'b1, 8'hff, 1'b1, 9'h1ff};
      end else if (step_ff[0] == 1'b0) begin
        scl_ff <= 1'b0;
        sda_low_ff <= ~frame_ff[26];
        frame_ff <= {frame_ff[25:0], 1'b1};
      end else begin
        scl_ff <= 1'b1;
        if (step_ff == 7'h11 || step_ff == 7'h23 || step_ff == ack_step) begin
          if (sda_s) nack_ff <= 1'b1;
        end
        if (rd_ff && step_ff >= 7'h3b && step_ff <= 7'h49) begin
          rdat_ff <= {rdat_ff[6:0], sda_s};
        end
      end
    end
  end
  assign link.scl = scl_ff;
  assign link.sda_host_out = 1'b0;
  assign link.sda_host_oe = sda_low_ff;
endmodule // pmic_host

//--- pmic_link_chk.sv
// assertions on the serial link and reset line between the two ends
`timescale 1ns/10ps
module pmic_link_chk
  import pmic_pkg::*;
#(
  parameter longint RESET_CYC = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe,
  input wire logic push_button_enable_n,
  input wire logic reset_sink_oe
);
  logic scl_ff, sda_ff, rd_ff;
  logic [3:0] bit_ff;
  logic [1:0] byte_ff;
  logic [7:0] shift_ff;
  longint cnt_ff;
  wire start_ev = scl && scl_ff && sda_ff && !sda;
  wire rise_ev = scl && !scl_ff;
  // line history and position of the bit within a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_ff, sda_ff} <= 2'h3;
      {bit_ff, byte_ff, rd_ff} <= 7'h00;
      shift_ff <= 8'h00;
    end else begin
      {scl_ff, sda_ff} <= {scl, sda};
      if (start_ev) begin
        {bit_ff, byte_ff} <= 6'h00;
      end else if (rise_ev && bit_ff != 4'h8) begin
        bit_ff <= bit_ff + 4'h1;
        shift_ff <= {shift_ff[6:0], sda};
      end else if (rise_ev) begin
        bit_ff <= 4'h0;
        byte_ff <= byte_ff + 2'h1;
        rd_ff <= (byte_ff == 2'h0) ? shift_ff[0] : rd_ff;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 0;
    end else begin
      cnt_ff <= reset_sink_oe ? cnt_ff + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_press; $fell(push_button_enable_n); endsequence
  sequence s_addr_slot; rise_ev && bit_ff == 4'h8 && byte_ff == 2'h0; endsequence
  sequence s_ack_slot; rise_ev && bit_ff == 4'h8 && !(rd_ff && byte_ff == 2'h1); endsequence
  property p_press_reset; s_press |-> ##[1:8] reset_sink_oe; endproperty
  a_press_reset: assert property (p_press_reset) else $error("no reset on press");
  property p_reset_min; $rose(reset_sink_oe) |-> reset_sink_oe[*8]; endproperty
  a_reset_min: assert property (p_reset_min) else $error("reset too short");
  property p_reset_max; reset_sink_oe |-> cnt_ff < RESET_CYC; endproperty
  a_reset_max: assert property (p_reset_max) else $error("reset not released");
  property p_dev_scl_low; $changed(sda_dev_oe) |-> !scl; endproperty
  a_dev_scl_low: assert property (p_dev_scl_low) else $error("data moved, clock high");
  property p_ack_hold; $rose(sda_dev_oe) |-> sda_dev_oe[*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("data bit too short");
  property p_scl_high; $rose(scl) |-> scl[*8]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  property p_addr; s_addr_slot |-> shift_ff[7:1] == SLAVE_ADDR; endproperty
  a_addr: assert property (p_addr) else $error("wrong address byte");
  property p_ack; s_ack_slot |-> !sda; endproperty
  a_ack: assert property (p_ack) else $error("missing acknowledge");
endmodule // pmic_link_chk

//--- pmic_enable_sequencer_tb.sv
// self-checking bench: processor end and sequencer joined over the link
`timescale 1ns/10ps
module pmic_enable_sequencer_tb
  import pmic_pkg::*;
;
  localparam longint RST = 200;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, forced_pwm, output_span_select;
  logic temp_over_160, temp_below_140, buck1_output_ok;
  logic buck_regulator_1, buck_regulator_2, buck_regulator_3, linear_regulator_4;
  logic [5:0] output_voltage_select;
  logic [7:0] paddr, v;
  logic [31:0] pwdata, prdata, rd_q;
  int error_cnt, n_tests, cyc, n;
  wire [3:0] regs_w = {buck_regulator_1, buck_regulator_2, buck_regulator_3, linear_regulator_4};
  wire [6:0] volt_w = {output_span_select, output_voltage_select};
  pmic_link_if u_pmic_link_if ();
  pmic_sequencer #(.RESET_CYC(RST)) u_pmic_sequencer (.pclk, .presetn,
    .link(u_pmic_link_if.device), .temp_over_160, .temp_below_140, .buck1_output_ok,
    .buck_regulator_1, .buck_regulator_2, .buck_regulator_3, .linear_regulator_4,
    .output_voltage_select, .output_span_select, .forced_pwm);
  pmic_host u_pmic_host (.pclk, .presetn, .link(u_pmic_link_if.host), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  pmic_link_chk #(.RESET_CYC(RST)) u_pmic_link_chk (.pclk, .presetn,
    .scl(u_pmic_link_if.scl), .sda(u_pmic_link_if.sda), .sda_dev_oe(u_pmic_link_if.sda_dev_oe),
    .push_button_enable_n(u_pmic_link_if.push_button_enable_n),
    .reset_sink_oe(u_pmic_link_if.reset_sink_oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic regs(input logic [3:0] exp);
    @(negedge pclk);
    chk(32'(regs_w), 32'(exp));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // values settle before the falling edge and still stand at the next rising one
    do begin
      @(negedge pclk);
      ok = pready;
      rd_q = prdata;
      @(posedge pclk);
    end while (ok !== 1'b1);
    {psel, penable} <= 2'h0;
  endtask
  task automatic xfer(input logic rd, input logic [7:0] ofs, input logic [7:0] d);
    int k;
    apb(1'b1, APB_CMD, {15'h0000, rd, ofs, d});
    k = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0000_0000);
      k++;
    end while (rd_q[8] !== 1'b0 && k < 1000);
    chk(32'({pslverr, rd_q[9:8]}), 32'h0000_0000);
  endtask
  task automatic pins(input logic hold, input logic on3);
    apb(1'b1, APB_PINS, {30'h0000_0000, on3, hold});
    repeat (8) @(posedge pclk);
  endtask
  task automatic button(input logic lvl);
    @(posedge pclk);
    u_pmic_link_if.push_button_enable_n <= lvl;
    repeat (8) @(posedge pclk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      close_out();
    end
  end
  initial begin
    {psel, penable, pwrite, temp_over_160, temp_below_140, presetn} = 6'h00;
    {paddr, pwdata, buck1_output_ok} = {40'h00_0000_0000, 1'b1};
    u_pmic_link_if.push_button_enable_n = 1'b1;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    v = 8'($urandom(32'h0000_b769));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    regs(4'h0);
    chk(32'({forced_pwm, volt_w}), 32'({MODE_RST, VOLTAGE_RST}));
    chk(32'(u_pmic_link_if.processor_reset_out_n), 32'h0000_0001);
    $display("test reset finished");
    @(posedge pclk);
    u_pmic_link_if.push_button_enable_n <= 1'b0;
    n = 0;
    do begin @(negedge pclk); n++; end while (u_pmic_link_if.reset_sink_oe !== 1'b1 && n < 20);
    n = 0;
    do begin @(negedge pclk); n++; end while (u_pmic_link_if.reset_sink_oe === 1'b1 && n < 400);
    chk(32'(n), 32'(RST));
    regs(4'hf);
    chk(32'(u_pmic_link_if.processor_reset_out_n), 32'h0000_0001);
    pins(1'b1, 1'b0);
    button(1'b1);
    regs(4'hd);
    $display("test press finished");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      xfer(1'b0, OFS_VOLTAGE, v);
      chk(32'(volt_w), 32'(v[6:0]));
      xfer(1'b0, OFS_MODE, v);
      chk(32'(forced_pwm), 32'(v[0]));
      xfer(1'b0, OFS_RESERVED, ~v);
      chk(32'(volt_w), 32'(v[6:0]));
      xfer(1'b0, OFS_CTRL_STATUS, {v[7:3], WEXACT_RST, v[1:0]});
      regs({v[0], 3'h5});
    end
    xfer(1'b0, OFS_CTRL_STATUS, {5'h00, WEXACT_RST, 2'h1});
    xfer(1'b1, OFS_VOLTAGE, 8'h00);
    chk(32'(volt_w), 32'(v[6:0]));
    chk(32'(rd_q[7:0]), 32'({1'b0, v[6:0]}));
    buck1_output_ok <= 1'b0;
    xfer(1'b1, OFS_CTRL_STATUS, 8'h00);
    chk(32'(rd_q[7:0]), 32'({5'h00, WEXACT_RST, 1'b0, 1'b1}));
    $display("test registers finished");
    pins(1'b1, 1'b1);
    regs(4'hf);
    pins(1'b0, 1'b1);
    regs(4'h0);
    button(1'b0);
    repeat (RST + 20) @(posedge pclk);
    regs(4'hf);
    pins(1'b0, 1'b0);
    regs(4'hf);
    button(1'b1);
    regs(4'h0);
    $display("test shutdown finished");
    pins(1'b1, 1'b0);
    @(posedge pclk);
    temp_over_160 <= 1'b1;
    repeat (8) @(posedge pclk);
    regs(4'h0);
    @(posedge pclk);
    temp_over_160 <= 1'b0;
    repeat (8) @(posedge pclk);
    regs(4'h0);
    @(posedge pclk);
    temp_below_140 <= 1'b1;
    repeat (8) @(posedge pclk);
    regs(4'hd);
    $display("test thermal finished");
    close_out();
  end
endmodule // pmic_enable_sequencer_tb
